// >>> wdt_pkg.sv
// Purpose: shared constants and types of the windowed watchdog timer
// Assumes: 32-bit Avalon-MM register access, one aligned word per register
// Notes: register offsets are word indices; byte address is four times the index
package wdt_pkg;
   // register indices and bus geometry
   localparam int ADDR_W = 18;
   localparam logic [15:0] IDX_RESTART = 16'hFF99;
   localparam logic [15:0] IDX_OPTION = 16'hFF9A;
   localparam logic [15:0] IDX_STATUS = 16'hFF9B;
   localparam logic [15:0] IDX_CONTROL = 16'hFF9C;
   // restart register key and read-back values
   localparam logic [7:0] KEY_VALUE = 8'hAC;
   localparam logic [7:0] RESTART_RD_ON = 8'h9A;
   localparam logic [7:0] RESTART_RD_OFF = 8'h1A;
   localparam logic [3:0] BYTE_LANE0 = 4'h1;
   // option byte field positions
   localparam int OPT_LOCK_BIT = 0;
   localparam int OPT_OVF_LSB = 1;
   localparam int OPT_ENABLE_BIT = 4;
   localparam int OPT_WIN_LSB = 5;
   // control register field: low-speed oscillator stop
   localparam int CTL_OSC_STOP_BIT = 0;
   // overflow count base exponent and counter width
   localparam int OVF_BASE_EXP = 10;
   localparam int CNT_W = 17;
   // exempt data windows in the top of the address space
   localparam logic [15:0] EXEMPT_A_LO = 16'hFB00;
   localparam logic [15:0] EXEMPT_A_HI = 16'hFFCF;
   localparam logic [15:0] EXEMPT_B_LO = 16'hFFE0;
   // reset cause codes shown in the status register
   localparam logic [2:0] CAUSE_NONE = 3'h0;
   localparam logic [2:0] CAUSE_OVERFLOW = 3'h1;
   localparam logic [2:0] CAUSE_BAD_KEY = 3'h2;
   localparam logic [2:0] CAUSE_BIT_OP = 3'h3;
   localparam logic [2:0] CAUSE_WINDOW = 3'h4;
   localparam logic [2:0] CAUSE_FETCH = 3'h5;
   localparam logic [2:0] CAUSE_DATA = 3'h6;
   // bus handshake states
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } wdt_bus_type;
endpackage

// >>> wdt_ls_tick.sv
// Purpose: turn the low-speed oscillator clock into one-cycle count ticks
// Assumes: low-speed clock far slower than clk
// Notes: two-flop synchroniser, edge taken from the second stage only
`timescale 1ns/1ps
module wdt_ls_tick (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic ls_clk,
   output logic tick
);
   import wdt_pkg::*;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
   } wdt_tick_state_type;

   wdt_tick_state_type s_q;
   wdt_tick_state_type s_d;

   // first stage feeds only the second stage
   always_comb begin
      s_d = s_q;
      s_d.sync1 = ls_clk;
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // rising edge of the synchronised low-speed clock
   assign tick = ce & s_q.sync2 & ~s_q.prev;
endmodule // wdt_ls_tick

// >>> wdt_top.sv
// Purpose: windowed watchdog timer with restart key, window and access checks
// Assumes: option byte stable at reset release; bus signals synchronous to clk
// Notes: the reset controller consumes wdt_reset_req; system reset clears all
//
// Summary of operation
// [R1] key ACH written clears and restarts counter
// [R2] restart register reset value 9AH or 1AH
// [R3] non-key write requests reset, deferred if stopped
// [R4] bit-manipulation access requests reset, deferred likewise
// [R5] restart register reads return reset value
// [R6] enable option starts counting and access checks
// [R7] later writes in closed window request reset
// [R8] first write after reset skips window check
// [R9] overflow without key write requests reset
// [R10] fetch outside configured memory requests reset
// [R11] data access outside memory requests reset, exemptions
// [R12] overflow after 2^(10+n) low-speed cycles
// [R13] window code selects 25/50/75/100 percent open
// [R14] closed from zero until open part starts
// [R15] software never combines code 000 with window 00
// [R16] lock option decides pause in halt/stop
// [R17] oscillator stop holds count without clearing
// [R18] counting continues during flash self-programming
// [R19] overflow after clear within two low-speed periods
// [R20] key write on last count still prevents reset
// [R21] counter clocked by low-speed oscillator
// [R22] every watchdog reset sets reset flag
// [R23] each cause gives one reset request pulse
`timescale 1ns/1ps
module wdt_top #(
   parameter int CNT_WIDTH = wdt_pkg::CNT_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic lowspeed_clk,
   input wire logic [7:0] option_byte,
   input wire logic cpu_halt,
   input wire logic cpu_stop,
   input wire logic [15:0] memory_size_rom_top,
   input wire logic [15:0] memory_size_ram_base,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic data_valid,
   input wire logic [15:0] data_addr,
   input wire logic [wdt_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_bit_op,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic wdt_reset_req,
   output logic watchdog_reset_flag
);
   import wdt_pkg::*;

   typedef struct packed {
      wdt_bus_type bus;
      logic wait_n;
      logic [31:0] rdata;
      logic opt_loaded;
      logic [7:0] opt;
      logic osc_stop;
      logic [CNT_WIDTH-1:0] cnt;
      logic first_done;
      logic pending;
      logic [2:0] pend_cause;
      logic fired;
      logic req;
      logic flag;
      logic [2:0] cause;
   } wdt_state_type;

   wdt_state_type s_q;
   wdt_state_type s_d;
   logic tick;

   // true when a configured memory area holds the address
   function automatic logic in_memory(input logic [15:0] a, input logic [15:0] rom_top,
                                      input logic [15:0] ram_base);
      in_memory = (a < rom_top) || (a >= ram_base);
   endfunction

   // decode a byte address to a register index match
   function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
      hits = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
   endfunction

   // low-speed edges become ticks of the counter [R21]
   wdt_ls_tick u_tick (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .ls_clk(lowspeed_clk),
      .tick(tick)
   );

   logic enabled;
   logic ls_running;
   logic [2:0] ovf_code;
   logic [1:0] win_code;
   logic [CNT_WIDTH-1:0] limit_m1;
   logic [CNT_WIDTH-1:0] open_start;
   logic [CNT_WIDTH-1:0] quarter;
   logic [7:0] restart_rd;
   logic bus_go;
   logic wr_restart;
   logic [2:0] hit_cause;
   logic hit;

   // option fields and derived thresholds
   always_comb begin
      enabled = s_q.opt_loaded & s_q.opt[OPT_ENABLE_BIT]; // [R6]
      ovf_code = s_q.opt[OPT_OVF_LSB +: 3];
      win_code = s_q.opt[OPT_WIN_LSB +: 2];
      // limit is 2^(10+n); overflow fires on the tick that finds the count at limit-1 [R12]
      limit_m1 = CNT_WIDTH'((1 << (OVF_BASE_EXP + int'(ovf_code))) - 1);
      quarter = CNT_WIDTH'((1 << (OVF_BASE_EXP + int'(ovf_code))) >> 2);
      // window opens after (3 - code) quarters of the period [R13] [R14]
      open_start = CNT_WIDTH'(quarter * (CNT_WIDTH'(3) - CNT_WIDTH'(win_code)));
      // stoppable oscillator pauses in halt, stop or software stop [R16] [R17]
      ls_running = s_q.opt[OPT_LOCK_BIT] | ~(cpu_halt | cpu_stop | s_q.osc_stop);
      restart_rd = s_q.opt[OPT_ENABLE_BIT] ? RESTART_RD_ON : RESTART_RD_OFF; // [R2]
   end

   // bus request seen while idle is answered on the following edge
   always_comb begin
      bus_go = (avs_read | avs_write) && (s_q.bus == BUS_IDLE);
      wr_restart = bus_go && avs_write && hits(avs_address, IDX_RESTART);
   end

   // pick one cause, highest priority first
   always_comb begin
      hit = 1'b0;
      hit_cause = CAUSE_NONE;
      if (enabled && wr_restart && avs_bit_op) begin
         hit = 1'b1; // [R4]
         hit_cause = CAUSE_BIT_OP;
      end else if (enabled && wr_restart && (avs_byteenable[0] == 1'b0 ||
                   avs_writedata[7:0] != KEY_VALUE)) begin
         hit = 1'b1; // [R3]
         hit_cause = CAUSE_BAD_KEY;
      end else if (enabled && wr_restart && s_q.first_done && s_q.cnt < open_start) begin
         hit = 1'b1; // [R7]
         hit_cause = CAUSE_WINDOW;
      end else if (enabled && fetch_valid &&
                   !in_memory(fetch_addr, memory_size_rom_top, memory_size_ram_base)) begin
         hit = 1'b1; // [R10]
         hit_cause = CAUSE_FETCH;
      end else if (enabled && data_valid &&
                   !in_memory(data_addr, memory_size_rom_top, memory_size_ram_base) &&
                   !(data_addr >= EXEMPT_A_LO && data_addr <= EXEMPT_A_HI) &&
                   !(data_addr >= EXEMPT_B_LO)) begin
         hit = 1'b1; // [R11]
         hit_cause = CAUSE_DATA;
      end else if (enabled && ls_running && tick && s_q.cnt == limit_m1 &&
                   !wr_restart) begin
         hit = 1'b1; // [R9] a key write on this tick wins [R20]
         hit_cause = CAUSE_OVERFLOW;
      end
   end

   // next state
   always_comb begin
      s_d = s_q;
      s_d.req = 1'b0;
      // option byte caught on the first edge after reset release
      if (!s_q.opt_loaded) begin
         s_d.opt_loaded = 1'b1;
         s_d.opt = option_byte;
      end
      // counter advances on low-speed ticks, also during flash work [R18] [R21]
      if (enabled && ls_running && tick) begin
         s_d.cnt = CNT_WIDTH'(s_q.cnt + CNT_WIDTH'(1));
      end
      // valid key write clears the count; first write ignores the window [R1] [R8]
      if (enabled && wr_restart && !hit && !s_q.fired) begin
         s_d.cnt = '0; // tick phase is not reset, so overflow may drift up to one period [R19]
         s_d.first_done = 1'b1;
      end
      // a cause fires now, or waits for the low-speed clock to resume [R3] [R4]
      if (hit && !s_q.fired && !s_q.pending) begin
         if (ls_running) begin
            s_d.fired = 1'b1;
            s_d.req = 1'b1; // [R23]
            s_d.flag = 1'b1; // [R22]
            s_d.cause = hit_cause;
         end else begin
            s_d.pending = 1'b1;
            s_d.pend_cause = hit_cause;
         end
      end else if (s_q.pending && ls_running && !s_q.fired) begin
         s_d.pending = 1'b0;
         s_d.fired = 1'b1;
         s_d.req = 1'b1; // [R23]
         s_d.flag = 1'b1; // [R22]
         s_d.cause = s_q.pend_cause;
      end
      // bus handshake: one wait cycle, then waitrequest low for one edge
      case (s_q.bus)
         BUS_IDLE: begin
            if (avs_read | avs_write) begin
               s_d.bus = BUS_ACK;
               s_d.wait_n = 1'b1;
               s_d.rdata = '0;
               if (avs_read) begin
                  if (hits(avs_address, IDX_RESTART)) begin
                     s_d.rdata = {24'h000000, restart_rd}; // [R5]
                  end else if (hits(avs_address, IDX_OPTION)) begin
                     s_d.rdata = {24'h000000, s_q.opt};
                  end else if (hits(avs_address, IDX_STATUS)) begin
                     s_d.rdata = {8'h00, s_q.fired, s_q.pending, s_q.first_done,
                                  (s_q.cnt >= open_start), s_q.cause,
                                  CNT_W'(s_q.cnt)};
                  end else if (hits(avs_address, IDX_CONTROL)) begin
                     s_d.rdata = {31'h00000000, s_q.osc_stop};
                  end
               end else if (hits(avs_address, IDX_CONTROL) && avs_byteenable[0]) begin
                  s_d.osc_stop = avs_writedata[CTL_OSC_STOP_BIT]; // [R17]
               end
            end
         end
         BUS_ACK: begin
            s_d.bus = BUS_IDLE;
            s_d.wait_n = 1'b0;
         end
         default: begin
            s_d.bus = BUS_IDLE;
            s_d.wait_n = 1'b0;
         end
      endcase
   end

   // whole state registered; ce low freezes everything
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = ~s_q.wait_n;
   assign wdt_reset_req = s_q.req;
   assign watchdog_reset_flag = s_q.flag;
endmodule // wdt_top

// >>> wdt_top_props.sv
// Purpose: port-level checks of the windowed watchdog
// Assumes: option byte held steady between resets
// Notes: bound from the bench top; restart write checks need enable set
`timescale 1ns/1ps
module wdt_top_props #(
   parameter int CNT_WIDTH = wdt_pkg::CNT_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] option_byte,
   input wire logic cpu_halt,
   input wire logic cpu_stop,
   input wire logic [15:0] memory_size_rom_top,
   input wire logic [15:0] memory_size_ram_base,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic data_valid,
   input wire logic [15:0] data_addr,
   input wire logic [wdt_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_bit_op,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic wdt_reset_req,
   input wire logic watchdog_reset_flag
);
   import wdt_pkg::*;
   logic run, kw, fg, dg;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // armed and no earlier cause fired: a new cause must show
   assign run = option_byte[OPT_ENABLE_BIT] && !cpu_halt && !cpu_stop && !watchdog_reset_flag;
   assign kw = avs_write && avs_address == {IDX_RESTART, 2'b00};
   assign fg = fetch_addr >= memory_size_rom_top && fetch_addr < memory_size_ram_base;
   assign dg = data_addr >= memory_size_rom_top && data_addr < memory_size_ram_base
      && !(data_addr >= EXEMPT_A_LO && data_addr <= EXEMPT_A_HI) && data_addr < EXEMPT_B_LO;
   wait_one_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("bus answer late");
   key_read_a: assert property (avs_read && avs_address == {IDX_RESTART, 2'b00}
      && !avs_waitrequest |-> avs_readdata[7:0] == (option_byte[OPT_ENABLE_BIT] ?
      RESTART_RD_ON : RESTART_RD_OFF)) else $error("restart read-back wrong");
   bad_key_a: assert property (run && kw && $rose(avs_write) && !avs_bit_op
      && avs_writedata[7:0] != KEY_VALUE |-> ##[1:3] wdt_reset_req) else $error("bad key kept");
   bit_op_a: assert property (run && kw && $rose(avs_write) && avs_bit_op
      |-> ##[1:3] wdt_reset_req) else $error("bit access kept");
   fetch_out_a: assert property (run && fetch_valid && fg |-> ##[1:2] wdt_reset_req)
      else $error("stray fetch kept");
   data_out_a: assert property (run && data_valid && dg |-> ##[1:2] wdt_reset_req)
      else $error("stray data access kept");
   off_quiet_a: assert property (!option_byte[OPT_ENABLE_BIT] |-> !wdt_reset_req)
      else $error("request while disabled");
   req_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req ##1 !wdt_reset_req)
      else $error("request not one pulse");
   flag_set_a: assert property (wdt_reset_req |-> ##[0:1] watchdog_reset_flag [*3])
      else $error("flag not set and held");
endmodule // wdt_top_props

// >>> wdt_top_tb.sv
// Purpose: self-checking bench of the windowed watchdog
// Assumes: low-speed clock of 80 ns drives the ticks
// Notes: read answers checked against a queue of notes
`timescale 1ns/1ps
module wdt_top_tb;
   import wdt_pkg::*;
   localparam logic [17:0] RA = {IDX_RESTART, 2'b00}, SA = {IDX_STATUS, 2'b00};
   localparam logic [31:0] CM = 32'h008E0000;
   logic clk = 0, reset_n = 0, lowspeed_clk = 0, cpu_halt = 0, avs_read = 0, avs_write = 0;
   logic avs_bit_op = 0, fetch_valid = 0, data_valid = 0, avs_waitrequest, wdt_reset_req;
   logic watchdog_reset_flag;
   logic ce = 1, cpu_stop = 0;
   logic [3:0] avs_byteenable = BYTE_LANE0;
   logic [7:0] option_byte = 8'h00;
   logic [15:0] fetch_addr = 16'h0, data_addr = 16'h0;
   logic [17:0] avs_address = 18'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [31:0] exp_q[$], msk_q[$];
   int error_cnt = 0, tests_run = 0;
   wdt_top i_dut (.clk, .reset_n, .ce, .lowspeed_clk, .option_byte, .cpu_halt,
      .cpu_stop, .memory_size_rom_top(16'h8000), .memory_size_ram_base(16'hFF00),
      .fetch_valid, .fetch_addr, .data_valid, .data_addr, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_bit_op, .avs_readdata,
      .avs_waitrequest, .wdt_reset_req, .watchdog_reset_flag);
   // ticks are slow against clk so the synchroniser sees each edge
   initial forever #5 clk = ~clk;
   initial forever #40 lowspeed_clk = ~lowspeed_clk;
   task automatic test_done;
      if (error_cnt == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // read data taken at the edge where waitrequest is sampled low; flops update after it
   always @(posedge clk) begin
      if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
         tests_run++;
         if ((avs_readdata & msk_q[0]) !== exp_q[0]) begin
            error_cnt++;
            $display("FAIL readdata %h exp %h seen %h", avs_address, exp_q[0],
               avs_readdata & msk_q[0]);
         end
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d, input logic b);
      int n;
      @(posedge clk);
      {avs_write, avs_read, avs_bit_op} <= {w, !w, b};
      {avs_address, avs_writedata} <= {a, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         $display("FAIL waitrequest exp 0 seen 1");
      end
      {avs_write, avs_read, avs_bit_op} <= 3'b000;
   endtask
   task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0, 1'b0);
   endtask
   task automatic cause(input logic [2:0] c);
      rd(SA, {8'h00, c != 3'h0, 3'b000, c, 17'h0}, CM);
   endtask
   task automatic rst(input logic [7:0] o, input logic h);
      // software never pairs overflow code 000 with window 00
      if (o[OPT_OVF_LSB +: 3] == 3'h0 && o[OPT_WIN_LSB +: 2] == 2'h0) begin
         o[OPT_WIN_LSB] = 1'b1;
      end
      @(posedge clk);
      {reset_n, option_byte, cpu_halt} <= {1'b0, o, h};
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge lowspeed_clk);
   endtask
   task automatic acc(input logic f, input logic [15:0] a);
      @(posedge clk);
      {fetch_valid, data_valid, fetch_addr, data_addr} <= {f, !f, a, a};
      @(posedge clk);
      {fetch_valid, data_valid} <= 2'b00;
      repeat (4) @(posedge clk);
   endtask
   // main sequence, one reset before each test case
   initial begin
      logic [7:0] k;
      void'($urandom(39));
      rst(8'h00, 0);
      rd(RA, 32'h1A, 32'hFFFFFFFF);
      bus(1, RA, 32'h55, 0);
      acc(1, 16'h9000);
      cause(CAUSE_NONE);
      rd(18'h00010, 32'h0, 32'hFFFFFFFF);
      rst(8'h70, 0);
      rd(RA, 32'h9A, 32'hFF);
      bus(1, RA, {24'h0, KEY_VALUE}, 0);
      bus(1, RA, {24'h0, KEY_VALUE}, 0);
      rd(SA, 32'h00200000, 32'h00EFFFF0);
      tk(1010);
      cause(CAUSE_NONE);
      bus(1, RA, {24'h0, KEY_VALUE}, 0);
      rd(SA, 32'h00200000, 32'h00EFFFF0);
      tk(1030);
      cause(CAUSE_OVERFLOW);
      // 25 percent open window, second write must land past three quarters
      rst(8'h12, 0);
      bus(1, RA, {24'h0, KEY_VALUE}, 0);
      tk(1540);
      bus(1, RA, {24'h0, KEY_VALUE}, 0);
      cause(CAUSE_NONE);
      bus(1, RA, {24'h0, KEY_VALUE}, 0);
      cause(CAUSE_WINDOW);
      k = 8'($urandom());
      if (k == KEY_VALUE) k = 8'h00;
      rst(8'h70, 0);
      bus(1, RA, {24'h0, k}, 0);
      cause(CAUSE_BAD_KEY);
      rst(8'h70, 0);
      bus(1, RA, {24'h0, KEY_VALUE}, 1);
      cause(CAUSE_BIT_OP);
      // key value without byte lane 0 counts as a wrong key
      rst(8'h70, 0);
      avs_byteenable <= 4'h2;
      bus(1, RA, {24'h0, KEY_VALUE}, 0);
      avs_byteenable <= BYTE_LANE0;
      cause(CAUSE_BAD_KEY);
      rst(8'h70, 0);
      acc(0, 16'hFB00 + 16'($urandom_range(16'h04CF)));
      cause(CAUSE_NONE);
      acc(1, 16'h8000 + 16'($urandom_range(16'h6FFF)));
      cause(CAUSE_FETCH);
      rst(8'h70, 0);
      acc(0, 16'hC000 ^ 16'($urandom_range(16'h0FFF)));
      cause(CAUSE_DATA);
      // halt, then oscillator stop, hold the count; a halted bad key waits
      rst(8'h7E, 1);
      tk(50);
      rd(SA, 32'h0, 32'h1FFFF);
      cpu_halt <= 1'b0;
      tk(50);
      rd(SA, 32'h20, 32'h1FFE0);
      bus(1, {IDX_CONTROL, 2'b00}, 32'h1, 0);
      tk(50);
      rd(SA, 32'h20, 32'h1FFE0);
      bus(1, {IDX_CONTROL, 2'b00}, 32'h0, 0);
      cpu_stop <= 1'b1;
      tk(50);
      rd(SA, 32'h20, 32'h1FFE0);
      cpu_stop <= 1'b0;
      // clock enable low freezes the count as well
      ce <= 1'b0;
      tk(50);
      @(posedge clk);
      ce <= 1'b1;
      rd(SA, 32'h20, 32'h1FFE0);
      cpu_halt <= 1'b1;
      bus(1, RA, 32'h33, 0);
      rd(SA, 32'h00400000, 32'h00C00000);
      cpu_halt <= 1'b0;
      cause(CAUSE_BAD_KEY);
      test_done();
   end
   // run takes about 31000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      $display("FAIL timeout exp done seen hang");
      test_done();
   end
endmodule // wdt_top_tb
bind wdt_top wdt_top_props #(.CNT_WIDTH(CNT_WIDTH)) i_props (.clk, .reset_n, .option_byte,
   .cpu_halt, .cpu_stop, .memory_size_rom_top, .memory_size_ram_base, .fetch_valid,
   .fetch_addr, .data_valid, .data_addr, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_bit_op, .avs_readdata, .avs_waitrequest, .wdt_reset_req, .watchdog_reset_flag);
